// ---- inc/pit_pkg.sv ----
// Package of constants for the priority interrupt and interval timer block
package pit_pkg;
   // Control byte field positions
   localparam int PRIO_LSB = 0;             // Complemented current priority, 3 bits
   localparam int BYPASS_BIT = 3;           // Priority compare override
   localparam int IVAL_LSB = 4;             // Three interval enables, bits 4..6
   localparam int GPO_BIT = 7;              // General purpose output bit
   localparam logic [7:0] CTRL_RESET = 8'h00; // Control latch after reset
   // Restart instruction template: bits 3..5 carry the level, rest high
   localparam logic [7:0] RST_TEMPLATE = 8'hC7;
   // Timing
   localparam int PHI2_HZ = 200_000_000;    // Bus clock rate
   localparam int BASE_US_X10 = 1;          // Base interval 0.1 ms in units of 0.1 ms
   localparam int BASE_DIV = PHI2_HZ / 10_000 * BASE_US_X10; // Cycles per 0.1 ms
   localparam int DECADE = 10;              // Each further stage divides by ten
   localparam int NUM_RATES = 9;            // Selectable divided-clock intervals
   localparam int NUM_DEC = 4;              // Decade stages after the base
endpackage

// ---- rtl/pit_ctrl.sv ----
// Priority interrupt controller with interval timer and one control port
`timescale 1ns/100ps
// Functional notes
// (RL1) Peripherals request by holding active-low lines low
// (RL2) Eight levels, seven highest, highest pending wins
// (RL3) Interrupt only when level exceeds current priority
// (RL4) Bit three bypasses compare, level zero served
// (RL5) Unchosen requesters must keep requests asserted
// (RL6) Acknowledge blocks interrupts until next port write
// (RL7) Software initialises priority when enabling interrupts
// (RL8) Priority bits written as ones complement
// (RL9) Bits four to six gate three interval rates
// (RL10) Several enabled rates combine logically
// (RL11) Timer request toggles on each interval tick
// (RL12) Every port write loads byte and rearms
// (RL13) Software writes all fields every time
// (RL14) Rewriting unchanged bits causes no glitch
// (RL15) One port address, all eight lines match
// (RL16) Bit seven drives general output, holds value
// (RL17) Timer request enters at configurable level
// (RL18) Three interval inputs chosen from nine rates
// (RL19) Write strobe from address match and write
// (RL20) Divide down to 0.1 ms then decades
// (RL21) Acknowledge drives restart, clears pending request
// (RL22) Bit seven output is inverted
// (RL23) Reset clears latch, no interrupts until write
module pit_ctrl #(
   parameter logic [7:0] PORT_ADDR = 8'h00, // Jumpered port address
   parameter logic [2:0] TIMER_LEVEL = 3'h7, // Level of the timer request
   parameter logic [3:0] SEL0 = 4'h1,        // Rate index for bit 4
   parameter logic [3:0] SEL1 = 4'h4,        // Rate index for bit 5
   parameter logic [3:0] SEL2 = 4'h8         // Rate index for bit 6
) (
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic [7:0] addr,      // Port address lines
   input wire logic wr_strobe,       // Processor write strobe, one cycle
   input wire logic [7:0] wr_data,   // Data out bus
   input wire logic [7:0] req_n,     // Peripheral requests, active low
   input wire logic inta,            // Interrupt acknowledge pulse
   output logic int_req,             // Interrupt request to processor
   output logic [7:0] rst_data,      // Restart instruction, valid with rst_oe_n low
   output logic rst_oe_n,            // Low while driving the data in bus
   output logic gpo_n                // Inverted bit 7 output
);
   typedef enum logic [0:0] {
      PIT_ARMED = 1'b0,               // Will raise an interrupt
      PIT_BLOCKED = 1'b1              // Waiting for a port write
   } pit_state_t;

   // Divider chain: base counter and decade counters
   // The chain free-runs from reset; software cannot phase-align it, so the
   // first interval after enabling a rate may be shorter than a full period
   logic [15:0] base_cnt_reg, base_cnt_next;
   logic [3:0] dec_cnt_reg [pit_pkg::NUM_DEC], dec_cnt_next [pit_pkg::NUM_DEC];
   logic [pit_pkg::NUM_RATES-1:0] rate_reg, rate_next; // Square waves of the nine rates
   logic [pit_pkg::NUM_RATES-1:0] tick;                // One-cycle pulse per half period
   // Control and priority state
   logic [7:0] ctrl_reg, ctrl_next;             // Written control byte
   pit_state_t state_reg, state_next;
   logic gate_reg, gate_next;                   // Gated interval level, for edge finding
   logic treq_reg, treq_next;                   // Timer request flip-flop, high = requesting
   logic int_reg, int_next;
   logic [7:0] rdat_reg, rdat_next;
   logic oe_n_reg, oe_n_next;
   logic gpo_n_reg, gpo_n_next;
   // Working signals
   logic port_wr;
   logic [7:0] pend;
   logic [2:0] win;
   logic any;
   logic [2:0] cur;
   logic gate;

   // Divider next state; base divide gives 0.1 ms, decades slow it further
   always_comb begin
      base_cnt_next = base_cnt_reg + 16'h0001;
      rate_next = rate_reg;
      tick = '0;
      for (int i = 0; i < pit_pkg::NUM_DEC; i++) begin
         dec_cnt_next[i] = dec_cnt_reg[i];
      end
      // Base stage toggles every half of the 0.1 ms interval
      if (base_cnt_reg == 16'(pit_pkg::BASE_DIV / 2 - 1)) begin // RL20
         base_cnt_next = 16'h0000;
         tick[0] = 1'b1;
         // Cascade: stage i fires after ten half periods of stage below
         // Ticks ripple within one cycle, so all rates stay phase locked
         for (int i = 0; i < pit_pkg::NUM_DEC; i++) begin
            if (tick[2*i]) begin
               if (dec_cnt_reg[i] == 4'(pit_pkg::DECADE - 1)) begin
                  dec_cnt_next[i] = 4'h0;
                  tick[2*i+2] = 1'b1;
               end else begin
                  dec_cnt_next[i] = dec_cnt_reg[i] + 4'h1;
               end
               // Intermediate rate at half the decade, giving nine taps
               if (dec_cnt_reg[i] == 4'h4 || dec_cnt_reg[i] == 4'(pit_pkg::DECADE - 1)) begin
                  tick[2*i+1] = 1'b1;
               end
            end
         end
      end
      rate_next = rate_reg ^ tick;
   end

   // Divider registers
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         base_cnt_reg <= 16'h0000;
         rate_reg <= '0;
         // Counters restart so every rate begins low after reset
         for (int i = 0; i < pit_pkg::NUM_DEC; i++) begin
            dec_cnt_reg[i] <= 4'h0;
         end
      end else begin
         base_cnt_reg <= base_cnt_next;
         rate_reg <= rate_next;
         dec_cnt_reg <= dec_cnt_next;
      end
   end

   // Priority, timer and port logic
   always_comb begin
      // Full eight-bit compare against the jumpered address
      port_wr = wr_strobe && (addr == PORT_ADDR); // RL15 RL19
      // Selected rates ORed with the inverted enable bits and ANDed, several combine
      // A disabled rate passes a one, so only enabled rates shape the gate
      // With nothing enabled the gate stays low and the flip-flop holds
      gate = (~ctrl_reg[pit_pkg::IVAL_LSB] | rate_reg[SEL0]) // RL9 RL18
           & (~ctrl_reg[pit_pkg::IVAL_LSB+1] | rate_reg[SEL1]) // RL10
           & (~ctrl_reg[pit_pkg::IVAL_LSB+2] | rate_reg[SEL2])
           & (|ctrl_reg[pit_pkg::IVAL_LSB+2:pit_pkg::IVAL_LSB]);
      gate_next = gate;
      treq_next = treq_reg;
      if (gate && !gate_reg) begin
         treq_next = ~treq_reg; // RL11
      end
      // Timer request merged at its jumpered level
      pend = ~req_n; // RL1
      if (treq_reg) begin
         pend[TIMER_LEVEL] = 1'b1; // RL17
      end
      win = 3'h0;
      any = 1'b0;
      for (int l = 0; l < 8; l++) begin
         if (pend[l]) begin
            win = 3'(l); // RL2
            any = 1'b1;
         end
      end
      // Stored priority is written inverted
      cur = ~ctrl_reg[pit_pkg::PRIO_LSB+2:pit_pkg::PRIO_LSB]; // RL8
      state_next = state_reg;
      int_next = 1'b0;
      if (state_reg == PIT_ARMED && any
          && (ctrl_reg[pit_pkg::BYPASS_BIT] || win > cur)) begin // RL3 RL4
         int_next = 1'b1;
      end
      rdat_next = rdat_reg;
      oe_n_next = 1'b1;
      ctrl_next = ctrl_reg;
      gpo_n_next = gpo_n_reg;
      case (state_reg)
         PIT_ARMED: begin
            if (inta && int_reg) begin
               // Drive restart with winning level, then block
               rdat_next = pit_pkg::RST_TEMPLATE | {2'b00, win, 3'b000}; // RL21
               oe_n_next = 1'b0;
               int_next = 1'b0;
               state_next = PIT_BLOCKED; // RL6
               if (win == TIMER_LEVEL && treq_reg) begin
                  treq_next = 1'b0;
               end
            end
         end
         PIT_BLOCKED: begin
            int_next = 1'b0;
         end
         default: begin
            state_next = PIT_BLOCKED;
         end
      endcase
      if (port_wr) begin
         // Whole byte reloads; equal values leave outputs unchanged
         ctrl_next = wr_data; // RL12 RL14
         state_next = PIT_ARMED;
         gpo_n_next = ~wr_data[pit_pkg::GPO_BIT]; // RL16 RL22
      end
   end

   // Control, priority and output registers
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         ctrl_reg <= pit_pkg::CTRL_RESET;
         state_reg <= PIT_BLOCKED; // RL23
         gate_reg <= 1'b0;
         treq_reg <= 1'b0;
         int_reg <= 1'b0;
         rdat_reg <= pit_pkg::RST_TEMPLATE;
         oe_n_reg <= 1'b1;
         gpo_n_reg <= 1'b1;
      end else begin
         ctrl_reg <= ctrl_next;
         state_reg <= state_next;
         gate_reg <= gate_next;
         treq_reg <= treq_next;
         int_reg <= int_next;
         rdat_reg <= rdat_next;
         oe_n_reg <= oe_n_next;
         gpo_n_reg <= gpo_n_next;
      end
   end

   assign int_req = int_reg;
   assign rst_data = rdat_reg;
   assign rst_oe_n = oe_n_reg;
   assign gpo_n = gpo_n_reg;
endmodule

// ---- test/pit_ctrl_properties.sv ----
// Port checks for the interrupt controller
`timescale 1ns/100ps
module pit_props #(
   parameter logic [7:0] PORT_ADDR = 8'h00 // Decoded port address
) (
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic [7:0] addr,
   input wire logic wr_strobe,
   input wire logic [7:0] wr_data,
   input wire logic [7:0] req_n,
   input wire logic inta,
   input wire logic int_req,
   input wire logic [7:0] rst_data,
   input wire logic rst_oe_n,
   input wire logic gpo_n
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);
   wire hit = wr_strobe && addr == PORT_ADDR; // Taken port write
   wire ack = inta && int_req; // Taken acknowledge
   chk_ack_restart: assert property (ack |=> !rst_oe_n && rst_data[7:6] == 2'h3
      && rst_data[2:0] == 3'h7) else $error("bad restart byte");
   chk_oe_single: assert property (!rst_oe_n |=> rst_oe_n)
      else $error("restart drive too long");
   chk_oe_cause: assert property ($fell(rst_oe_n) |-> $past(ack))
      else $error("restart drive without ack");
   chk_ack_blocks: assert property (ack |=> !int_req ##1 !int_req)
      else $error("interrupt after ack");
   chk_top_level: assert property (ack && !req_n[7] |=> rst_data == 8'hFF)
      else $error("level seven not chosen");
   chk_gpo_invert: assert property (hit |=> gpo_n == ~$past(wr_data[7]))
      else $error("output bit not inverted");
   chk_gpo_hold: assert property (!hit |=> $stable(gpo_n))
      else $error("output bit moved");
   chk_reset_quiet: assert property ($fell(sys_rst) |-> !int_req && rst_oe_n && gpo_n)
      else $error("bad reset state");
   cover property (ack ##1 !rst_oe_n);
   cover property (hit ##1 !gpo_n);
   cover property (ack && !req_n[0]);
endmodule
bind pit_ctrl pit_props #(.PORT_ADDR(PORT_ADDR)) u_props (.*);

// ---- test/pit_periph.sv ----
// Peripheral request model
`timescale 1ns/100ps
module pit_periph (
   input wire logic clk_sys,
   input wire logic [7:0] want, // Levels needing service
   output logic [7:0] req_n
);
   initial req_n = 8'hFF; // Nobody requests at start
   // Lines stay low as long as service is wanted, served or not
   always @(posedge clk_sys) begin
      req_n <= ~want;
   end
endmodule

// ---- test/pit_ctrl_tb.sv ----
// Bench for the interrupt controller and timer
`timescale 1ns/100ps
module pit_ctrl_tb;
   typedef struct packed {
      logic [7:0] wd; // Control byte
      logic [7:0] rq; // Requesting levels
      logic fire; // Interrupt expected
      logic [7:0] rs; // Restart expected
   } pit_row_t;
   localparam pit_row_t ROWS [7] = '{
      '{8'h05, 8'h08, 1'b1, 8'hDF},
      '{8'h05, 8'h04, 1'b0, 8'h00},
      '{8'h07, 8'h01, 1'b0, 8'h00},
      '{8'h08, 8'h01, 1'b1, 8'hC7},
      '{8'h00, 8'h80, 1'b0, 8'h00},
      '{8'h07, 8'h52, 1'b1, 8'hF7},
      '{8'h08, 8'h81, 1'b1, 8'hFF}};
   logic clk_sys = 1'b0;
   logic sys_rst, wr_strobe, inta, int_req, rst_oe_n, gpo_n;
   logic [7:0] addr, wr_data, want, req_n, rst_data;
   int n_errors = 0;
   int n_tests = 0;
   always #2.5 clk_sys = ~clk_sys;
   pit_ctrl #(.TIMER_LEVEL(3'h2), .SEL0(4'h0)) uut (.clk_sys(clk_sys), .sys_rst(sys_rst),
      .addr(addr), .wr_strobe(wr_strobe), .wr_data(wr_data), .req_n(req_n), .inta(inta),
      .int_req(int_req), .rst_data(rst_data), .rst_oe_n(rst_oe_n), .gpo_n(gpo_n));
   pit_periph u_periph (.clk_sys(clk_sys), .want(want), .req_n(req_n));
   task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // One strobe, then room for the two-edge arming delay
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      addr <= a;
      wr_data <= d;
      wr_strobe <= 1'b1;
      @(posedge clk_sys);
      wr_strobe <= 1'b0;
      repeat (3) @(posedge clk_sys);
   endtask
   // Acknowledge, read the restart byte, then see the block hold
   task automatic ack(input logic [7:0] exp);
      inta <= 1'b1;
      @(posedge clk_sys);
      inta <= 1'b0;
      #1 cmp({rst_oe_n, 7'h00}, 8'h00);
      cmp(rst_data, exp);
      repeat (2) @(posedge clk_sys);
      #1 cmp({7'h00, int_req}, 8'h00);
   endtask
   task automatic conclude;
      $display("tests %0d errors %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   initial begin
      sys_rst = 1'b1;
      addr = 8'h00;
      wr_data = 8'h00;
      wr_strobe = 1'b0;
      inta = 1'b0;
      want = 8'h80;
      repeat (6) @(posedge clk_sys);
      sys_rst <= 1'b0;
      repeat (4) @(posedge clk_sys);
      // A request is pending, yet nothing may happen before a write
      #1 cmp({int_req, rst_oe_n, gpo_n, 5'h00}, 8'h60);
      cmp(rst_data, 8'hC7);
      foreach (ROWS[i]) begin
         @(posedge clk_sys);
         want <= ROWS[i].rq;
         wr(8'h00, ROWS[i].wd);
         #1 cmp({7'h00, int_req}, {7'h00, ROWS[i].fire});
         if (ROWS[i].fire) ack(ROWS[i].rs);
      end
      // Still blocked: a foreign address must neither rearm nor set the output
      wr(8'h01, 8'h88);
      #1 cmp({int_req, gpo_n, 6'h00}, 8'h40);
      wr(8'h00, 8'h88);
      #1 cmp({int_req, gpo_n, 6'h00}, 8'h80);
      ack(8'hFF);
      wr(8'h00, 8'h88);
      #1 cmp({int_req, gpo_n, 6'h00}, 8'h80);
      ack(8'hFF);
      // Fastest rate on bit 4, timer sits at level 2 above priority 0
      want <= 8'h00;
      wr(8'h00, 8'h17);
      for (int k = 0; k < 30000 && int_req !== 1'b1; k++) @(posedge clk_sys);
      ack(8'hD7);
      conclude;
   end
   initial begin
      #400us;
      n_errors++;
      conclude;
   end
endmodule
